/* File: src/ochg_guard.sv */
// Overcurrent hiccup and thermal latch-off controller for two channels
// Functional notes
// - Compare sampled current against scaled limit
// - Limit rises 2A per added block
// - Over limit advances shared counter once
// - Drop of both channels to or below limit clears counter
// - Both channels over adds two counts
// - Counter full shuts both channels down
// - Both channels under clears counter
// - Cool-down equals soft-start interval
// - Counter cleared entering cool-down
// - Cool-down end starts soft-start
// - Successful soft-start raises power good
// - Retry shuts down only on overflow
// - Over-temperature latches both channels off
// - Only power-on reset clears thermal latch
// - Soft-start lasts fixed 4ms
// - Power good low in shutdown
`default_nettype none
module ochg_guard
	import ochg_pkg::*;
#(
	parameter int unsigned SS_CYCLES = OCHG_SS_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cycle_tick,
	input wire logic [7:0] current_ch_a,
	input wire logic [7:0] current_ch_b,
	input wire logic [1:0] config_select_a,
	input wire logic [1:0] config_select_b,
	input wire logic over_temp,
	output logic enable_ch_a,
	output logic enable_ch_b,
	output logic soft_start,
	output logic power_good_ch_a,
	output logic power_good_ch_b,
	output logic thermal_latched,
	output logic [3:0] overcurrent_count
);
	////////////////////////////////////////////////////////////////////////
	// Limit decode
	function automatic logic [7:0] oc_limit(input logic [1:0] slaves);
		oc_limit = 8'(OCHG_LIM_BASE + OCHG_LIM_STEP * {6'h00, slaves});
	endfunction : oc_limit

	// Two-stage synchronisers for pin-level inputs
	logic [1:0] ot_sync_q;
	logic [1:0] tick_sync_q;
	logic tick_prev_q;
	logic [1:0][1:0] cfg_a_sync_q;
	logic [1:0][1:0] cfg_b_sync_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ot_sync_q <= 2'h0;
			tick_sync_q <= 2'h0;
			tick_prev_q <= 1'b0;
			cfg_a_sync_q <= '0;
			cfg_b_sync_q <= '0;
		end
		else
		begin
			ot_sync_q <= {ot_sync_q[0], over_temp};
			tick_sync_q <= {tick_sync_q[0], cycle_tick};
			tick_prev_q <= tick_sync_q[1];
			cfg_a_sync_q <= {cfg_a_sync_q[0], config_select_a};
			cfg_b_sync_q <= {cfg_b_sync_q[0], config_select_b};
		end
	end
	wire logic cyc = tick_sync_q[1] & ~tick_prev_q;
	wire logic ot = ot_sync_q[1];

	// Configuration captured once after reset release; it is not rechecked
	logic [1:0] cfg_a_q;
	logic [1:0] cfg_b_q;
	logic cfg_done_q;
	logic [1:0] cfg_wait_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_a_q <= 2'h0;
			cfg_b_q <= 2'h0;
			cfg_done_q <= 1'b0;
			cfg_wait_q <= 2'h0;
		end
		else if (!cfg_done_q)
		begin
			// Wait until the strap synchronisers hold a settled value
			if (cfg_wait_q == 2'h2)
			begin
				cfg_a_q <= cfg_a_sync_q[1];
				cfg_b_q <= cfg_b_sync_q[1];
				cfg_done_q <= 1'b1;
			end
			else
				cfg_wait_q <= cfg_wait_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-cycle comparison
	// Sample and compare on the switching edge
	wire logic over_a = current_ch_a > oc_limit(cfg_a_q);
	wire logic over_b = current_ch_b > oc_limit(cfg_b_q);

	ochg_state_t state_q;
	logic [3:0] cnt_q;
	wire logic active = (state_q == OCHG_ST_RUN) || (state_q == OCHG_ST_SS);
	logic [4:0] cnt_sum;
	logic overflow;
	always_comb
	begin
		// Two events in one cycle add two
		cnt_sum = {1'b0, cnt_q} + {4'h0, over_a} + {4'h0, over_b};
		// Full value reached or passed; the counter then clears
		overflow = cyc && active && (cnt_sum >= {1'b0, OCHG_CNT_FULL});
	end

	// Timer for cool-down and soft-start
	logic tmr_start;
	logic tmr_done;
	// Power-on kick, else the first soft-start would never time out
	logic boot_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			boot_q <= 1'b1;
		else
			boot_q <= 1'b0;
	end
	wire logic tmr_kick = tmr_start || boot_q;
	// Fixed interval shared by cool-down and soft-start
	ochg_timer #(.CYCLES(SS_CYCLES)) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(tmr_kick),
		.done(tmr_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Hiccup state machine
	always_comb
	begin
		tmr_start = 1'b0;
		case (state_q)
			OCHG_ST_RUN: tmr_start = overflow && !ot;
			OCHG_ST_COOL: tmr_start = tmr_done && !ot;
			OCHG_ST_SS: tmr_start = overflow && !ot;
			default: tmr_start = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= OCHG_ST_SS;
		else
		begin
			// Over-temperature latches off from any state
			if (ot)
				state_q <= OCHG_ST_TSD;
			else
			begin
				case (state_q)
					OCHG_ST_RUN:
						if (overflow)
							state_q <= OCHG_ST_COOL;
					OCHG_ST_COOL:
						if (tmr_done)
							state_q <= OCHG_ST_SS;
					OCHG_ST_SS:
						if (overflow)
							state_q <= OCHG_ST_COOL;
						else if (tmr_done)
							state_q <= OCHG_ST_RUN;
					// Thermal latch leaves only by reset
					OCHG_ST_TSD: state_q <= OCHG_ST_TSD;
					default: state_q <= OCHG_ST_TSD;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overcurrent counter, updated once per switching cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= OCHG_CNT_RST;
		else if (overflow || !active)
			cnt_q <= OCHG_CNT_RST;
		else if (cyc)
		begin
			if (!over_a && !over_b)
				cnt_q <= OCHG_CNT_RST;
			else
				cnt_q <= cnt_sum[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_ch_a <= 1'b0;
			enable_ch_b <= 1'b0;
			soft_start <= 1'b0;
			power_good_ch_a <= 1'b0;
			power_good_ch_b <= 1'b0;
			thermal_latched <= 1'b0;
			overcurrent_count <= OCHG_CNT_RST;
		end
		else
		begin
			enable_ch_a <= active && !overflow && !ot;
			enable_ch_b <= active && !overflow && !ot;
			soft_start <= (state_q == OCHG_ST_SS) && !overflow && !ot;
			// Low in shutdown and during soft-start
			power_good_ch_a <= (state_q == OCHG_ST_RUN) && !overflow && !ot;
			power_good_ch_b <= (state_q == OCHG_ST_RUN) && !overflow && !ot;
			thermal_latched <= (state_q == OCHG_ST_TSD) || ot;
			overcurrent_count <= cnt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	// overflow must lead to disabled channels
	chk_overflow_shutdown: assert property (@(posedge clk) disable iff (!rst_n)
		overflow |=> !enable_ch_a && !enable_ch_b)
		else $error("channels still enabled after overflow");
	chk_cool_cleared: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == OCHG_ST_COOL) |-> cnt_q == 4'h0)
		else $error("counter not cleared in cool-down");
	chk_thermal_hold: assert property (@(posedge clk) disable iff (!rst_n)
		thermal_latched |=> thermal_latched && !enable_ch_a)
		else $error("thermal latch released");
	chk_thermal_entry: assert property (@(posedge clk) disable iff (!rst_n)
		ot |=> (state_q == OCHG_ST_TSD))
		else $error("thermal shutdown not entered");
	// no power good without run state
	chk_pg_low: assert property (@(posedge clk) disable iff (!rst_n)
		(power_good_ch_a || power_good_ch_b) |-> $past(state_q) == OCHG_ST_RUN)
		else $error("power good outside normal run");
	chk_double_step: assert property (@(posedge clk) disable iff (!rst_n)
		(cyc && active && over_a && over_b && !overflow) |=> cnt_q == $past(cnt_q) + 4'h2)
		else $error("double event not counted twice");
	chk_both_under: assert property (@(posedge clk) disable iff (!rst_n)
		(cyc && !over_a && !over_b) |=> cnt_q == 4'h0)
		else $error("counter not cleared when both under");
	chk_cool_to_ss: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == OCHG_ST_COOL && tmr_done && !ot) |=> state_q == OCHG_ST_SS)
		else $error("soft-start not started after cool-down");
	chk_saturate: assert property (@(posedge clk) disable iff (!rst_n)
		(cnt_q != 4'h0) |=> (cnt_q >= $past(cnt_q)) || (cnt_q == 4'h0))
		else $error("counter wrapped");
endmodule : ochg_guard
`default_nettype wire

/* File: src/ochg_pkg.sv */
// Constants and types for the overcurrent hiccup and thermal guard
`default_nettype none
package ochg_pkg;
	localparam int unsigned OCHG_CLK_HZ = 40_000_000;
	// Soft-start and cool-down interval in microseconds
	localparam int unsigned OCHG_SS_TIME_US = 4000;
	localparam int unsigned OCHG_SS_CYCLES = (OCHG_SS_TIME_US * (OCHG_CLK_HZ / 1_000_000));
	localparam int unsigned OCHG_CNT_W = 4;
	localparam logic [3:0] OCHG_CNT_FULL = 4'hf;
	localparam logic [3:0] OCHG_CNT_RST = 4'h0;
	localparam int unsigned OCHG_CUR_W = 8;
	// Limit step per slave block and base limit, in current units
	localparam logic [7:0] OCHG_LIM_STEP = 8'h02;
	localparam logic [7:0] OCHG_LIM_BASE = 8'h02;
	typedef enum logic [2:0] {
		OCHG_ST_RUN,
		OCHG_ST_COOL,
		OCHG_ST_SS,
		OCHG_ST_TSD
	} ochg_state_t;
endpackage : ochg_pkg
`default_nettype wire

/* File: src/ochg_timer.sv */
// Interval down-counter used for cool-down and soft-start
`default_nettype none
module ochg_timer
	import ochg_pkg::*;
#(
	parameter int unsigned CYCLES = OCHG_SS_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	output logic done
);
	localparam int unsigned W = $clog2(CYCLES + 1);
	// Refused at elaboration: a one-cycle interval loads zero and reaches the done compare only after the counter wraps
	if (CYCLES < 2)
	begin : g_bad_cycles
		$error("ochg_timer: CYCLES must be at least 2");
	end
	logic [W-1:0] cnt_q;
	logic run_q;
	// Load on start, count down, pulse done at zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				cnt_q <= W'(CYCLES - 1);
				run_q <= 1'b1;
			end
			else if (run_q)
			begin
				if (cnt_q == W'(1))
				begin
					run_q <= 1'b0;
					done <= 1'b1;
				end
				cnt_q <= cnt_q - W'(1);
			end
		end
	end
endmodule : ochg_timer
`default_nettype wire

/* File: bench/ochg_guard_tb.sv */
// Self-checking bench for the overcurrent hiccup guard
`default_nettype none
module ochg_guard_tb
	import ochg_pkg::*;
;
timeunit 1ns;
timeprecision 100ps;
localparam int SS = 20;
logic clk, rst_n, tick_in, hot;
logic [7:0] cur_a, cur_b;
logic [1:0] cfg_a, cfg_b;
logic en_a, en_b, ss, pg_a, pg_b, tl;
logic [3:0] cnt;
int n_errors, checks_done, cyc, t0;

// Short soft-start keeps every hiccup phase to a few dozen cycles
ochg_guard #(.SS_CYCLES(SS)) dut (.clk(clk), .rst_n(rst_n), .cycle_tick(tick_in),
	.current_ch_a(cur_a), .current_ch_b(cur_b), .config_select_a(cfg_a),
	.config_select_b(cfg_b), .over_temp(hot), .enable_ch_a(en_a), .enable_ch_b(en_b),
	.soft_start(ss), .power_good_ch_a(pg_a), .power_good_ch_b(pg_b),
	.thermal_latched(tl), .overcurrent_count(cnt));

////////////////////////////////////////////////////////////////////////////////
// Clock and hang guard
initial
begin
	clk = 1'b0;
	forever #12.5 clk = ~clk;
end

// Ceiling well above the few hundred cycles the tests need
always @(posedge clk)
begin
	cyc <= cyc + 1;
	if (cyc == 5000)
	begin
		n_errors++;
		wrap_up();
	end
end

////////////////////////////////////////////////////////////////////////////////
task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
	checks_done++;
	if (seen !== exp)
	begin
		n_errors++;
		$display("MISMATCH %s expected %h seen %h", what, exp, seen);
	end
endtask : chk

task automatic wrap_up();
	$display("checks %0d mismatches %0d", checks_done, n_errors);
	if (n_errors == 0 && checks_done > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask : wrap_up

// Config is sampled just after release, so it is set inside reset
task automatic do_reset(input logic [1:0] ca, input logic [1:0] cb);
	@(posedge clk);
	rst_n <= 1'b0;
	cfg_a <= ca;
	cfg_b <= cb;
	hot <= 1'b0;
	repeat (4) @(posedge clk);
	chk("outs_in_reset", {en_a, en_b, ss, pg_a, pg_b, tl, cnt[1:0]} | cnt[3:2], 8'h00);
	rst_n <= 1'b1;
	t0 = cyc;
endtask : do_reset

// One switching tick, spaced well beyond the synchroniser delay
task automatic tick(input logic [7:0] a, input logic [7:0] b);
	@(posedge clk);
	cur_a <= a;
	cur_b <= b;
	tick_in <= 1'b1;
	@(posedge clk);
	tick_in <= 1'b0;
	repeat (5) @(posedge clk);
endtask : tick

task automatic wait_pg();
	for (int i = 0; i < 3 * SS + 20 && pg_a !== 1'b1; i++)
		@(posedge clk);
	chk("pg_run", {pg_a, pg_b, en_a, en_b, ss}, 8'h1e);
endtask : wait_pg

////////////////////////////////////////////////////////////////////////////////
// start-up timing
task automatic t_startup();
	do_reset(2'h0, 2'h0);
	repeat (3) @(posedge clk);
	chk("ss_start", {en_a, en_b, ss, pg_a, pg_b}, 8'h1c);
	wait_pg();
	chk("ss_long", cyc - t0 >= SS && cyc - t0 <= SS + 6, 8'h01);
	$display("test startup done");
endtask : t_startup

task automatic t_count();
	repeat (3) tick(8'h03, 8'h00);
	chk("cnt_single", cnt, 4'h3);
	tick(8'h02, 8'h02);
	chk("cnt_at_limit", cnt, 4'h0);
	tick(8'h03, 8'h03);
	tick(8'h03, 8'h03);
	chk("cnt_double", cnt, 4'h4);
	tick(8'h00, 8'h03);
	chk("cnt_one_under", cnt, 4'h5);
	tick(8'h00, 8'h00);
	chk("cnt_clear", cnt, 4'h0);
	$display("test count done");
endtask : t_count

task automatic t_limit();
	do_reset(2'h3, 2'h1);
	wait_pg();
	tick(8'h08, 8'h04);
	chk("lim_equal", cnt, 4'h0);
	tick(8'h09, 8'h00);
	tick(8'h00, 8'h05);
	chk("lim_over", cnt, 4'h2);
	tick(8'h00, 8'h00);
	$display("test limit done");
endtask : t_limit

task automatic t_hiccup();
	repeat (7) tick(8'h09, 8'h09);
	chk("cnt_14", {en_a, en_b, cnt}, 8'h3e);
	t0 = cyc;
	tick(8'h09, 8'h09);
	chk("shut", {en_a, en_b, pg_a, pg_b, cnt}, 8'h00);
	tick(8'h09, 8'h09);
	chk("cool_hold", {en_a, en_b, ss, cnt}, 8'h00);
	for (int i = 0; i < 2 * SS && ss !== 1'b1; i++)
		@(posedge clk);
	chk("cool_len", cyc - t0 >= SS + 2 && cyc - t0 <= SS + 9, 8'h01);
	chk("retry_on", {en_a, en_b, ss, pg_a}, 8'h0e);
	tick(8'h09, 8'h00);
	chk("retry_cnt", {en_a, en_b, cnt}, 8'h31);
	tick(8'h00, 8'h00);
	wait_pg();
	$display("test hiccup done");
endtask : t_hiccup

// thermal latch, then the two-slave limit
task automatic t_thermal();
	@(posedge clk);
	hot <= 1'b1;
	repeat (6) @(posedge clk);
	chk("tsd", {tl, en_a, en_b, ss, pg_a, pg_b}, 8'h20);
	hot <= 1'b0;
	tick(8'h00, 8'h00);
	repeat (3 * SS) @(posedge clk);
	chk("tsd_held", {tl, en_a, en_b, pg_a}, 8'h08);
	do_reset(2'h2, 2'h2);
	@(posedge clk);
	chk("tsd_cleared", {7'h00, tl}, 8'h00);
	wait_pg();
	tick(8'h06, 8'h07);
	chk("lim_two", cnt, 4'h1);
	$display("test thermal done");
endtask : t_thermal

////////////////////////////////////////////////////////////////////////////////
// Main sequence
initial
begin
	rst_n = 1'b0;
	tick_in = 1'b0;
	hot = 1'b0;
	cur_a = 8'h00;
	cur_b = 8'h00;
	cfg_a = 2'h0;
	cfg_b = 2'h0;
	t_startup();
	t_count();
	t_limit();
	t_hiccup();
	t_thermal();
	wrap_up();
end
endmodule : ochg_guard_tb
`default_nettype wire
